// >>> src/astbg_pkg.sv
// ==========================================================================
// Shared constants for the serial transmitter and its controller
package astbg_pkg;
   // Device register indices on the link register port
   localparam logic [2:0] IDX_BAUD_HIGH = 3'h0;
   localparam logic [2:0] IDX_BAUD_LOW = 3'h1;
   localparam logic [2:0] IDX_CTRL_ONE = 3'h2;
   localparam logic [2:0] IDX_CTRL_TWO = 3'h3;
   localparam logic [2:0] IDX_STATUS_ONE = 3'h4;
   localparam logic [2:0] IDX_DATA_HIGH = 3'h6;
   localparam logic [2:0] IDX_DATA_LOW = 3'h7;
   // control_reg_one field positions
   localparam int CR1_LOOP_SELECT = 7;
   localparam int CR1_NINE_BIT = 4;
   localparam int CR1_IDLE_LINE_TYPE = 2;
   localparam int CR1_PARITY_ENABLE = 1;
   localparam int CR1_PARITY_TYPE = 0;
   // control_reg_two field positions
   localparam int CR2_TX_EMPTY_IRQ_ENABLE = 7;
   localparam int CR2_TRANSMITTER_ENABLE = 3;
   localparam int CR2_RECEIVER_ENABLE = 2;
   // status_reg_one field positions
   localparam int SR1_TX_BUFFER_EMPTY = 7;
   localparam int SR1_TRANSMIT_COMPLETE = 6;
   // data_reg_high field position
   localparam int DRH_TX_NINTH_BIT = 6;
   // Baud generator and frame timing
   localparam int DIV_W = 13;
   localparam logic [3:0] TICKS_LAST = 4'hF;   // 16 ticks per bit
   localparam logic [3:0] XFER_TICK = 4'h8;    // 9th tick of stop bit
   localparam logic [3:0] FRAME_LEN_8 = 4'hA;
   localparam logic [3:0] FRAME_LEN_9 = 4'hB;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RESET = 13'h0000;
   // Controller Avalon-MM byte offsets and bit positions
   localparam logic [3:0] OFS_COMMAND = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam int CMD_READ_BIT = 16;
   localparam int STAT_IRQ_BIT = 8;
   localparam int STAT_LINE_BIT = 9;
endpackage : astbg_pkg

// >>> src/astbg_link_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Register port and interrupt between controller and transmitter
interface astbg_link_if (
   input wire logic clock,
   input wire logic rst_n
);
   logic [2:0] reg_idx;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic tx_irq;

   modport dev_end (
      input clock, rst_n, reg_idx, reg_wr, reg_rd, reg_wdata,
      output reg_rdata, tx_irq
   );
   modport ctl_end (
      input clock, rst_n, reg_rdata, tx_irq,
      output reg_idx, reg_wr, reg_rd, reg_wdata
   );
endinterface : astbg_link_if

// >>> src/astbg_tx_dev.sv
`timescale 1ns/1ps
// ==========================================================================
// Behaviour
// RULE1: frame is 10 bits, or 11 in nine-bit
// RULE2: ninth bit from tx_ninth_bit, kept after sending
// RULE3: 13-bit modulus divisor counter shared by rx, tx
// RULE4: 16x tick for receiver, tx at tick/16
// RULE5: bit rate equals clock over 16 times divisor
// RULE6: zero divisor stops generator, nonzero starts it
// RULE7: high divisor write waits for low write
// RULE8: controller programs divisor, then ctrl one, two
// RULE9: start bit 0 at lsb, stop 1 at msb
// RULE10: parity replaces data msb, odd or even
// RULE11: buffer empty set on transfer, resets to one
// RULE12: next transfer 9/16 bit into stop bit
// RULE13: empty flag and enable raise tx interrupt
// RULE14: write only when empty; no start while set
// RULE15: enable rise sends preamble of ones first
// RULE16: line idles high when not sending frame
// RULE17: disable mid frame finishes frame first
// RULE18: controller waits empty flag before disabling
// RULE19: preamble between messages by enable toggle
// RULE20: tx and rx independent, one baud generator
// RULE21: status read then data write clears empty flag
// RULE22: data high written before data low commits
module astbg_tx_dev
   import astbg_pkg::*;
(
   // Link to the controller
   astbg_link_if.dev_end link,
   // Serial line and shared baud tick
   output logic txd,
   output logic rx_sample_tick,
   output logic transmit_complete
);
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } astbg_tx_state_t;

   // ======================================================================
   // Frame builder: start, data, optional parity, stop
   function automatic logic [10:0] build_frame(input logic [7:0] data,
                                               input logic ninth,
                                               input logic [7:0] cr1);
      logic [8:0] chr;
      logic par;
      chr = {ninth, data};
      if (cr1[CR1_NINE_BIT]) begin
         par = (^chr[7:0]) ^ cr1[CR1_PARITY_TYPE];
         if (cr1[CR1_PARITY_ENABLE]) chr[8] = par; // RULE10
         build_frame = {1'b1, chr, 1'b0}; // RULE2 RULE9
      end else begin
         par = (^chr[6:0]) ^ cr1[CR1_PARITY_TYPE];
         if (cr1[CR1_PARITY_ENABLE]) chr[7] = par; // RULE10
         build_frame = {2'b11, chr[7:0], 1'b0}; // RULE9
      end
   endfunction : build_frame

   logic [7:0] ctrl_one_r;
   logic [7:0] ctrl_two_r;
   logic [4:0] div_high_r;
   logic [DIV_W-1:0] divisor_r;
   logic [DIV_W-1:0] baud_cnt_r;
   logic tick16;
   logic [7:0] data_low_r;
   logic ninth_r;
   logic tx_buffer_empty_flag_r;
   logic tx_buffer_empty_flag_armed_r;
   logic te_prev_r;
   logic preamble_r;
   logic [10:0] next_frame_r;
   logic next_valid_r;
   astbg_tx_state_t state_r;
   logic [10:0] shift_r;
   logic [3:0] bits_left_r;
   logic [3:0] sub_r;
   logic [7:0] rdata_r;
   logic te;
   logic wr_low;
   logic bit_end;
   logic frame_end;
   logic xfer_point;
   logic boundary;
   logic load_pre;
   logic load_next;
   logic load_buf;
   logic [3:0] frame_len;

   assign te = ctrl_two_r[CR2_TRANSMITTER_ENABLE];
   assign wr_low = link.reg_wr && link.reg_idx == IDX_DATA_LOW; // RULE22
   assign frame_len = ctrl_one_r[CR1_NINE_BIT] ? FRAME_LEN_9
                                                : FRAME_LEN_8; // RULE1

   // ======================================================================
   // Register writes
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         ctrl_one_r <= CTRL_RESET;
         ctrl_two_r <= CTRL_RESET;
         div_high_r <= 5'h00;
         data_low_r <= 8'h00;
         ninth_r <= 1'b0;
      end else if (link.reg_wr) begin
         unique case (link.reg_idx)
            IDX_BAUD_HIGH: div_high_r <= link.reg_wdata[4:0]; // RULE7
            IDX_CTRL_ONE: ctrl_one_r <= link.reg_wdata;
            IDX_CTRL_TWO: ctrl_two_r <= link.reg_wdata;
            IDX_DATA_HIGH: ninth_r <= link.reg_wdata[DRH_TX_NINTH_BIT]; // RULE2
            IDX_DATA_LOW: data_low_r <= link.reg_wdata;
            default: ;
         endcase
      end
   end

   // Divisor in use changes only on the low write
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         divisor_r <= DIV_RESET;
      end else if (link.reg_wr && link.reg_idx == IDX_BAUD_LOW) begin
         divisor_r <= {div_high_r, link.reg_wdata}; // RULE7
      end
   end

   // ======================================================================
   // Baud generator: one tick every divisor clocks, shared with receiver
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         baud_cnt_r <= DIV_RESET;
      end else if (divisor_r == DIV_RESET || tick16) begin
         baud_cnt_r <= DIV_RESET; // RULE6
      end else begin
         baud_cnt_r <= baud_cnt_r + 13'h0001; // RULE3
      end
   end

   assign tick16 = divisor_r != DIV_RESET
                   && baud_cnt_r == divisor_r - 13'h0001; // RULE5 RULE6
   assign rx_sample_tick = tick16; // RULE4 RULE20

   // ======================================================================
   // Frame timing points
   assign bit_end = state_r == TX_SHIFT && tick16 && sub_r == TICKS_LAST;
   assign frame_end = bit_end && bits_left_r == 4'h1;
   assign xfer_point = state_r == TX_SHIFT && tick16
                       && bits_left_r == 4'h1 && sub_r == XFER_TICK
                       && te && !preamble_r && !tx_buffer_empty_flag_r
                       && !next_valid_r; // RULE12 RULE14
   assign boundary = te && tick16
                     && (state_r == TX_IDLE || frame_end); // RULE17
   assign load_pre = boundary && preamble_r; // RULE15
   assign load_next = boundary && !preamble_r && next_valid_r;
   assign load_buf = boundary && !preamble_r && !next_valid_r
                     && !tx_buffer_empty_flag_r; // RULE14

   // Preamble queued by each enable rise
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         te_prev_r <= 1'b0;
         preamble_r <= 1'b0;
      end else begin
         te_prev_r <= te;
         if (te && !te_prev_r) preamble_r <= 1'b1; // RULE15 RULE19
         else if (load_pre) preamble_r <= 1'b0;
      end
   end

   // Buffer empty flag: set wins over the clearing write
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         tx_buffer_empty_flag_r <= 1'b1; // RULE11
         tx_buffer_empty_flag_armed_r <= 1'b0;
      end else begin
         if (link.reg_rd && link.reg_idx == IDX_STATUS_ONE && tx_buffer_empty_flag_r) begin
            tx_buffer_empty_flag_armed_r <= 1'b1;
         end else if (wr_low) begin
            tx_buffer_empty_flag_armed_r <= 1'b0;
         end
         if (xfer_point || load_buf) tx_buffer_empty_flag_r <= 1'b1; // RULE11
         else if (wr_low && tx_buffer_empty_flag_armed_r) tx_buffer_empty_flag_r <= 1'b0; // RULE21
      end
   end

   // Early transfer into the held next frame
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         next_frame_r <= 11'h7FF;
         next_valid_r <= 1'b0;
      end else if (xfer_point) begin
         next_frame_r <= build_frame(data_low_r, ninth_r, ctrl_one_r);
         next_valid_r <= 1'b1; // RULE12
      end else if (load_next) begin
         next_valid_r <= 1'b0;
      end
   end

   // ======================================================================
   // Shift engine
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         state_r <= TX_IDLE;
         shift_r <= 11'h7FF;
         bits_left_r <= 4'h0;
         sub_r <= 4'h0;
      end else if (load_pre || load_next || load_buf) begin
         state_r <= TX_SHIFT;
         sub_r <= 4'h0;
         bits_left_r <= frame_len; // RULE1
         if (load_pre) shift_r <= 11'h7FF; // RULE15
         else if (load_next) shift_r <= next_frame_r;
         else shift_r <= build_frame(data_low_r, ninth_r, ctrl_one_r);
      end else if (frame_end) begin
         state_r <= TX_IDLE; // RULE17
         shift_r <= 11'h7FF;
         bits_left_r <= 4'h0;
         sub_r <= 4'h0;
      end else if (state_r == TX_SHIFT && tick16) begin
         sub_r <= sub_r + 4'h1; // RULE4
         if (bit_end) begin
            shift_r <= {1'b1, shift_r[10:1]};
            bits_left_r <= bits_left_r - 4'h1;
         end
      end
   end

   // Line output from a flop, idle high
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         txd <= 1'b1;
      end else if (state_r == TX_SHIFT && !frame_end) begin
         txd <= shift_r[0];
      end else if (load_pre || load_next || load_buf) begin
         txd <= 1'b1;
      end else begin
         txd <= 1'b1; // RULE16
      end
   end

   // ======================================================================
   // Register reads, one cycle after the strobe
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         rdata_r <= 8'h00;
      end else if (link.reg_rd) begin
         unique case (link.reg_idx)
            IDX_BAUD_HIGH: rdata_r <= {3'h0, divisor_r[12:8]};
            IDX_BAUD_LOW: rdata_r <= divisor_r[7:0];
            IDX_CTRL_ONE: rdata_r <= ctrl_one_r;
            IDX_CTRL_TWO: rdata_r <= ctrl_two_r;
            IDX_STATUS_ONE: rdata_r <= {tx_buffer_empty_flag_r, state_r == TX_IDLE,
                                        6'h00};
            IDX_DATA_HIGH: rdata_r <= {1'b0, ninth_r, 6'h00};
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign link.reg_rdata = rdata_r;
   assign link.tx_irq = tx_buffer_empty_flag_r && ctrl_two_r[CR2_TX_EMPTY_IRQ_ENABLE]; // RULE13
   assign transmit_complete = state_r == TX_IDLE;
endmodule : astbg_tx_dev

// >>> src/astbg_tx_ctl.sv
`timescale 1ns/1ps
// ==========================================================================
// Controller end: Avalon-MM slave turning commands into device accesses
module astbg_tx_ctl
   import astbg_pkg::*;
(
   // Link to the device
   astbg_link_if.ctl_end link,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_ACCESS = 4'b0010,
      HS_WAIT = 4'b0100,
      HS_DONE = 4'b1000
   } astbg_host_state_t;

   astbg_host_state_t state_r;
   logic [31:0] cmd_r;
   logic [7:0] last_rd_r;
   logic is_cmd_write;

   assign is_cmd_write = avs_write && avs_address == OFS_COMMAND;

   // ======================================================================
   // Access sequencer; every bus request ends in HS_DONE
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         state_r <= HS_IDLE;
         cmd_r <= 32'h0000_0000;
      end else begin
         unique case (state_r)
            HS_IDLE: begin
               if (is_cmd_write) begin
                  cmd_r <= avs_writedata; // RULE8 RULE22
                  state_r <= HS_ACCESS;
               end else if (avs_read || avs_write) begin
                  state_r <= HS_DONE;
               end
            end
            HS_ACCESS: state_r <= HS_WAIT;
            HS_WAIT: state_r <= HS_DONE;
            HS_DONE: state_r <= HS_IDLE;
         endcase
      end
   end

   // Capture device read data
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         last_rd_r <= 8'h00;
      end else if (state_r == HS_WAIT && cmd_r[CMD_READ_BIT]) begin
         last_rd_r <= link.reg_rdata;
      end
   end

   // Bus read data
   always_ff @(posedge link.clock or negedge link.rst_n) begin
      if (!link.rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (state_r == HS_IDLE && avs_read) begin
         unique case (avs_address)
            OFS_COMMAND: avs_readdata <= cmd_r;
            OFS_STATUS: avs_readdata <= {22'h000000, 1'b0,
                                         link.tx_irq, last_rd_r};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // One-cycle strobe on the device register port
   assign link.reg_idx = cmd_r[10:8];
   assign link.reg_wdata = cmd_r[7:0];
   assign link.reg_wr = state_r == HS_ACCESS && !cmd_r[CMD_READ_BIT];
   assign link.reg_rd = state_r == HS_ACCESS && cmd_r[CMD_READ_BIT];
   assign avs_waitrequest = (avs_read || avs_write) && state_r != HS_DONE;
endmodule : astbg_tx_ctl

// >>> sim/astbg_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Link and line checks
module astbg_asserts
   import astbg_pkg::*;
(
   // Link
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] reg_idx,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic tx_irq,
   // Line side
   input wire logic txd,
   input wire logic rx_sample_tick,
   input wire logic transmit_complete
);
   logic [4:0] hi_r;
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] gap_r;
   logic seen_r;
   logic commit;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   assign commit = reg_wr && reg_idx == IDX_BAUD_LOW;
   // Shadow divisor, committed by the low write only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hi_r <= 5'h00;
         div_r <= DIV_RESET;
      end else if (reg_wr && reg_idx == IDX_BAUD_HIGH) begin
         hi_r <= reg_wdata[4:0];
      end else if (commit) begin
         div_r <= {hi_r, reg_wdata};
      end
   end
   // Clocks since last tick; first tick after a commit is not judged
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gap_r <= DIV_RESET;
         seen_r <= 1'b0;
      end else begin
         gap_r <= rx_sample_tick ? DIV_RESET : gap_r + 13'h0001;
         seen_r <= commit ? 1'b0 : seen_r | rx_sample_tick;
      end
   end
   a_line_idle: assert property (transmit_complete |-> txd)
      else $error("line not idle while shifter idle");
   a_tick_gap: assert property (
      rx_sample_tick && seen_r |-> gap_r == div_r - 13'h0001)
      else $error("baud tick spacing wrong");
   a_no_tick: assert property (
      div_r == DIV_RESET && $past(div_r) == DIV_RESET |-> !rx_sample_tick)
      else $error("tick with zero divisor");
   a_irq_flag: assert property (
      reg_rd && reg_idx == IDX_STATUS_ONE && tx_irq
      |=> reg_rdata[SR1_TX_BUFFER_EMPTY])
      else $error("interrupt without empty flag");
   a_tc_status: assert property (
      reg_rd && reg_idx == IDX_STATUS_ONE
      |=> reg_rdata[SR1_TRANSMIT_COMPLETE] == $past(transmit_complete))
      else $error("complete flag differs from shifter");
   a_stop_high: assert property ($rose(transmit_complete) |-> $past(txd))
      else $error("frame ended without high stop bit");
   a_strobe_once: assert property (reg_wr |-> !reg_rd ##1 !reg_wr)
      else $error("write strobe wider than one cycle");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   c_tick: cover property (rx_sample_tick && seen_r);
   c_frame_end: cover property ($rose(transmit_complete));
   c_irq_read: cover property (reg_rd && tx_irq);
endmodule : astbg_asserts

// >>> sim/async_serial_tx_baud_gen_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: controller and transmitter joined by the link
module async_serial_tx_baud_gen_bench;
   import astbg_pkg::*;
   logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic txd, tick, tc;
   int errors, cmp_count, seed, bt, nb;
   logic [10:0] exp_q[$];
   astbg_link_if link (.clock(clock), .rst_n(rst_n));
   astbg_tx_ctl astbg_tx_ctl_i (.link(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   astbg_tx_dev astbg_tx_dev_i (.link(link), .txd(txd),
      .rx_sample_tick(tick), .transmit_complete(tc));
   astbg_asserts astbg_asserts_i (.clock(clock), .rst_n(rst_n),
      .reg_idx(link.reg_idx), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
      .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .tx_irq(link.tx_irq), .txd(txd), .rx_sample_tick(tick),
      .transmit_complete(tc));
   // Compare and count
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Sampled at each rising edge; data taken at the accepting edge
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // Device register write and read through the command word
   task automatic dw(input logic [2:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, OFS_COMMAND, {21'h000000, i, d}, q);
   endtask : dw
   task automatic dr(input logic [2:0] i, output logic [31:0] q);
      bus(1'b1, OFS_COMMAND, {15'h0000, 1'b1, 5'h00, i, 8'h00}, q);
      bus(1'b0, OFS_STATUS, 32'h00000000, q);
   endtask : dr
   // Model: f = {nine bit, parity on, parity odd}, LSB first
   function automatic logic [10:0] frame(logic [2:0] f, logic n8,
                                         logic [7:0] d);
      logic [8:0] b;
      b = {n8, d};
      if (f[2] && f[1]) b[8] = ^d ^ f[0];
      if (!f[2] && f[1]) b[7] = ^d[6:0] ^ f[0];
      return f[2] ? {1'b1, b, 1'b0} : {2'b01, b[7:0], 1'b0};
   endfunction : frame
   task automatic print_verdict();
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      print_verdict();
   end
   // Line monitor: sample mid-bit and compare with the model queue
   initial begin
      logic [10:0] f;
      forever begin
         @(negedge txd);
         f = 11'h000;
         repeat (bt / 2) @(negedge clock);
         for (int k = 0; k < nb; k++) begin
            if (k > 0) repeat (bt) @(negedge clock);
            f[k] = txd;
         end
         chk(f, exp_q.size() > 0 ? exp_q.pop_front() : 11'h000);
      end
   end
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [2:0] f;
      logic [7:0] d;
      logic n8;
      time t0;
      avs_address <= 4'h0;
      avs_writedata <= 32'h00000000;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      rst_n = 1'b0;
      seed = 48;
      bt = 48;
      nb = 10;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      dr(IDX_STATUS_ONE, q);
      chk(q[7:6], 2'b11);
      bus(1'b0, 4'h8, 32'h00000000, q);
      chk(q[10:0], 11'h000);
      dw(IDX_BAUD_HIGH, 8'h01);
      repeat (60) @(posedge clock);
      dw(IDX_BAUD_HIGH, 8'h00);
      d = 8'(3 + $unsigned($random(seed)) % 3);
      bt = 16 * d;
      dw(IDX_BAUD_LOW, d);
      for (int m = 0; m < 8; m++) begin
         f = 3'(m);
         nb = f[2] ? 11 : 10;
         dw(IDX_CTRL_ONE, {3'h0, f[2], 2'h0, f[1:0]});
         dw(IDX_CTRL_TWO, 8'h88);
         t0 = $time;
         n8 = 1'($random(seed));
         dw(IDX_DATA_HIGH, {1'b0, n8, 6'h00});
         for (int k = 0; k < 2; k++) begin
            do dr(IDX_STATUS_ONE, q); while (q[7] !== 1'b1);
            chk(q[8], 1'b1);
            d = 8'($random(seed));
            exp_q.push_back(frame(f, n8, d));
            dw(IDX_DATA_LOW, d);
            dr(IDX_STATUS_ONE, q);
            chk(q[8:7], 2'b00);
            if (k == 0) begin
               @(negedge txd);
               chk(($time - t0) >= (nb * bt - 4) * 25, 1'b1);
            end
         end
         do dr(IDX_STATUS_ONE, q); while (q[7] !== 1'b1);
         @(negedge txd);
         dw(IDX_CTRL_TWO, 8'h00);
         while (tc !== 1'b1) @(posedge clock);
      end
      chk(11'(exp_q.size()), 11'h000);
      print_verdict();
   end
endmodule : async_serial_tx_baud_gen_bench
